// ==== burst_sram.sv ====
// Flow-through burst SRAM access control
//==========================================
// Behaviour
// - Register all synchronous inputs on clock rise
// - Qualifier high freezes access state; sleep sequencer keeps running
// - Selected load with write high starts read
// - Read data driven only when output enabled
// - New access accepted right after read
// - Deselect on load three-states outputs at once
// - Burst counter gives four beats per address
// - Counter wraps on two low bits, strap order
// - Interleaved xors step, linear adds step
// - Advance steps counter ignoring selects
// - Read or write type kept for burst
// - Selected load with write low starts write
// - Write data taken next rise, overlaps
// - Only enabled lanes and parity written
// - Outputs off during write data phase
// - Sleep entry and exit take two cycles
// - Pending access dropped on sleep
// - Scan inputs sampled on scan clock rise
// - Scan output changes on scan clock fall
// - Outputs off first cycle after deselect
// - Comes up deselected with outputs off
`timescale 1ns/100ps
`include "sram_defines.svh"
module burst_sram
    import sram_pkg::*;
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_n_i,
    input  wire logic [`SRAM_ADDR_W-1:0] addr_i,
    input  wire logic                    clk_qualifier_n_i,
    input  wire logic                    chip_select_1_n_i,
    input  wire logic                    chip_select_2_i,
    input  wire logic                    chip_select_3_n_i,
    input  wire logic                    advance_or_load_i,
    input  wire logic                    write_select_n_i,
    input  wire logic [`SRAM_LANES-1:0]  byte_lane_write_n_i,
    input  wire logic                    output_drive_n_i,
    input  wire logic                    burst_order_i,
    input  wire logic                    sleep_request_i,
    input  wire logic [`SRAM_DATA_W-1:0] data_lines_i,
    input  wire logic [`SRAM_LANES-1:0]  parity_lines_i,
    output logic      [`SRAM_DATA_W-1:0] data_lines_o,
    output logic      [`SRAM_LANES-1:0]  parity_lines_o,
    output logic                         data_lines_oe_o,
    input  wire logic                    tck_i,
    input  wire logic                    tdi_i,
    input  wire logic                    tms_i,
    output logic                         tdo_o
);
    //==========================================
    // Storage and state
    logic [`SRAM_WORD_W-1:0] mem [`SRAM_DEPTH];
    sram_state_s             r, n;
    logic                    awake;
    logic                    selected;
    logic                    advance;
    logic                    mem_we;
    logic [1:0]              next_step;
    logic [1:0]              beat_low;
    logic [`SRAM_ADDR_W-1:0] beat_addr;
    logic [`SRAM_ADDR_W-1:0] rd_addr;
    logic [`SRAM_WORD_W-1:0] wr_word;
    logic [`SRAM_WORD_W-1:0] rd_fetch;

    // Replace only the lanes whose enable is low, parity bit included
    function automatic logic [`SRAM_WORD_W-1:0] merge_lanes(
        input logic [`SRAM_WORD_W-1:0] old_w,
        input logic [`SRAM_WORD_W-1:0] new_w,
        input logic [`SRAM_LANES-1:0]  lanes_n
    );
        logic [`SRAM_WORD_W-1:0] res;
        res = old_w;
        for (int i = 0; i < `SRAM_LANES; i++) begin
            if (!lanes_n[i]) begin
                res[i*`SRAM_LANE_W +: `SRAM_LANE_W] = new_w[i*`SRAM_LANE_W +: `SRAM_LANE_W];
                res[`SRAM_DATA_W + i] = new_w[`SRAM_DATA_W + i];
            end
        end
        return res;
    endfunction : merge_lanes

    //==========================================
    // Burst address of the next beat
    assign next_step = 2'(r.step + 2'h1);
    burst_sequencer u_seq (
        .start_i       (r.base[1:0]),
        .step_i        (next_step),
        .interleaved_i (r.order_sync[1]),
        .beat_o        (beat_low)
    );
    assign beat_addr = {r.base[`SRAM_ADDR_W-1:`SRAM_BURST_W], beat_low};

    // Command decode on the sampled pins
    assign awake    = (r.sleep == SLP_AWAKE);
    assign selected = !chip_select_1_n_i && chip_select_2_i && !chip_select_3_n_i;
    assign advance  = awake && !clk_qualifier_n_i && advance_or_load_i;
    assign mem_we   = awake && !clk_qualifier_n_i && r.write_pend;
    assign wr_word  = {parity_lines_i, data_lines_i};
    assign rd_addr  = advance_or_load_i ? beat_addr : addr_i;

    // Read word, with the write completing on this edge forwarded
    always_comb begin
        rd_fetch = mem[rd_addr];
        if (r.write_pend && (r.wr_addr == rd_addr)) begin
            rd_fetch = merge_lanes(mem[rd_addr], wr_word, r.wr_lanes_n);
        end
    end

    //==========================================
    // Next state
    always_comb begin
        n = r;
        n.sleep_sync = {r.sleep_sync[0], sleep_request_i};
        n.order_sync = {r.order_sync[0], burst_order_i};
        // Sleep sequencer runs even while clock qualifier stalls
        case (r.sleep)
            SLP_AWAKE: begin
                if (r.sleep_sync[1]) begin
                    n.sleep     = SLP_ENTER;
                    n.sleep_cnt = 2'(`SRAM_SLEEP_STEP_CYC - 2);
                end
            end
            SLP_ENTER: begin
                if (r.sleep_cnt == 2'h0) begin
                    n.sleep = SLP_ASLEEP;
                end else begin
                    n.sleep_cnt = 2'(r.sleep_cnt - 2'h1);
                end
            end
            SLP_ASLEEP: begin
                if (!r.sleep_sync[1]) begin
                    n.sleep     = SLP_EXIT;
                    n.sleep_cnt = 2'(`SRAM_SLEEP_STEP_CYC - 2);
                end
            end
            SLP_EXIT: begin
                if (r.sleep_cnt == 2'h0) begin
                    n.sleep = SLP_AWAKE;
                end else begin
                    n.sleep_cnt = 2'(r.sleep_cnt - 2'h1);
                end
            end
            default: begin
                n.sleep = SLP_AWAKE;
            end
        endcase
        if (!awake) begin
            // Anything in flight is abandoned
            n.op         = OP_IDLE;
            n.read_valid = 1'b0;
            n.write_pend = 1'b0;
        end else if (!clk_qualifier_n_i) begin
            n.write_pend = 1'b0;
            n.read_valid = 1'b0;
            if (advance_or_load_i) begin
                n.step = next_step;
                case (r.op)
                    OP_READ: begin
                        n.read_valid = 1'b1;
                        n.rd_word    = rd_fetch;
                    end
                    OP_WRITE: begin
                        n.write_pend = 1'b1;
                        n.wr_addr    = beat_addr;
                        n.wr_lanes_n = byte_lane_write_n_i;
                    end
                    default: begin
                        n.op = OP_IDLE;
                    end
                endcase
            end else if (selected) begin
                n.base = addr_i;
                n.step = 2'h0;
                if (write_select_n_i) begin
                    n.op         = OP_READ;
                    n.read_valid = 1'b1;
                    n.rd_word    = rd_fetch;
                end else begin
                    n.op         = OP_WRITE;
                    n.write_pend = 1'b1;
                    n.wr_addr    = addr_i;
                    n.wr_lanes_n = byte_lane_write_n_i;
                end
            end else begin
                n.op = OP_IDLE;
            end
        end
    end

    // State register; powers up deselected
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Self-timed write into the array
    always_ff @(posedge clk_sys_i) begin
        if (mem_we) begin
            mem[r.wr_addr] <= merge_lanes(mem[r.wr_addr], wr_word, r.wr_lanes_n);
        end
    end

    //==========================================
    // Pin drivers
    assign data_lines_o    = r.rd_word[`SRAM_DATA_W-1:0];
    assign parity_lines_o  = r.rd_word[`SRAM_WORD_W-1:`SRAM_DATA_W];
    assign data_lines_oe_o = r.read_valid && !output_drive_n_i && awake;

    scan_port u_scan (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .tck_i     (tck_i),
        .tdi_i     (tdi_i),
        .tms_i     (tms_i),
        .tdo_o     (tdo_o)
    );

    //==========================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_load_read;
        awake && !clk_qualifier_n_i && !advance_or_load_i && selected && write_select_n_i;
    endsequence
    sequence s_load_write;
        awake && !clk_qualifier_n_i && !advance_or_load_i && selected && !write_select_n_i;
    endsequence
    sequence s_write_data;
        !data_lines_oe_o && r.write_pend;
    endsequence

    property p_read_start;
        s_load_read |=> r.read_valid && r.op == OP_READ && r.base == $past(addr_i);
    endproperty
    a_read_start: assert property (p_read_start) else $error("read not started");

    property p_read_drive;
        s_load_read ##1 (awake && !output_drive_n_i) |-> data_lines_oe_o;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");

    property p_stall;
        (awake && clk_qualifier_n_i && r.sleep_sync[1] == 1'b0) |=>
            $stable(r.base) && $stable(r.step) && $stable(r.read_valid) && $stable(r.op);
    endproperty
    a_stall: assert property (p_stall) else $error("state moved in stall");

    property p_deselect;
        (awake && !clk_qualifier_n_i && !advance_or_load_i && !selected) |=> !data_lines_oe_o;
    endproperty
    a_deselect: assert property (p_deselect) else $error("outputs on after deselect");

    property p_write;
        s_load_write |=> s_write_data;
    endproperty
    a_write: assert property (p_write) else $error("write data phase wrong");

    property p_write_done;
        (r.write_pend && mem_we) |=> !r.write_pend || $past(advance_or_load_i) || $past(selected);
    endproperty
    a_write_done: assert property (p_write_done) else $error("write not completed");

    property p_advance;
        advance |=> r.step == $past(next_step) && r.op == $past(r.op);
    endproperty
    a_advance: assert property (p_advance) else $error("burst step lost");

    property p_burst_type;
        (advance && r.op == OP_WRITE) |=> r.write_pend && !r.read_valid;
    endproperty
    a_burst_type: assert property (p_burst_type) else $error("burst type changed");

    property p_sleep_entry;
        (awake && r.sleep_sync[1]) |=> !awake ##1 (r.sleep == SLP_ASLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry timing");

    property p_sleep_drop;
        !awake |=> !r.write_pend && !data_lines_oe_o;
    endproperty
    a_sleep_drop: assert property (p_sleep_drop) else $error("access kept in sleep");

    property p_powerup;
        $rose(rst_n_i) |-> !data_lines_oe_o;
    endproperty
    a_powerup: assert property (@(posedge clk_sys_i) p_powerup) else $error("outputs on at power-up");

    // Load taken on the edge right after a read load
    property p_back_to_back;
        s_load_read ##1 s_load_write |=> r.op == OP_WRITE && r.write_pend;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("access after read refused");

    // No drive while write data is on the lines
    property p_write_quiet;
        r.write_pend |-> !data_lines_oe_o;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("outputs on in write data phase");

    // Enabled lane and its parity bit take the bus data
    property p_lane_written;
        (mem_we && !r.wr_lanes_n[0]) |=>
            {mem[$past(r.wr_addr)][`SRAM_DATA_W], mem[$past(r.wr_addr)][7:0]} ==
            $past({parity_lines_i[0], data_lines_i[7:0]});
    endproperty
    a_lane_written: assert property (p_lane_written) else $error("enabled lane not written");

    // Disabled lane and its parity bit stay as they were
    property p_lane_kept;
        (mem_we && r.wr_lanes_n[1]) |=>
            {mem[$past(r.wr_addr)][`SRAM_DATA_W + 1], mem[$past(r.wr_addr)][15:8]} ==
            $past({mem[r.wr_addr][`SRAM_DATA_W + 1], mem[r.wr_addr][15:8]});
    endproperty
    a_lane_kept: assert property (p_lane_kept) else $error("disabled lane altered");

    // First advance in interleaved order flips the low bit
    property p_beat_interleaved;
        (advance && r.op == OP_WRITE && r.step == 2'h0 && r.order_sync[1]) |=>
            r.wr_addr[1:0] == (r.base[1:0] ^ 2'h1);
    endproperty
    a_beat_interleaved: assert property (p_beat_interleaved) else $error("interleaved beat wrong");

    // First advance in linear order adds one with wrap
    property p_beat_linear;
        (advance && r.op == OP_WRITE && r.step == 2'h0 && !r.order_sync[1]) |=>
            r.wr_addr[1:0] == 2'(r.base[1:0] + 2'h1);
    endproperty
    a_beat_linear: assert property (p_beat_linear) else $error("linear beat wrong");

    // Sleep exit takes two edges
    property p_sleep_exit;
        (r.sleep == SLP_ASLEEP && !r.sleep_sync[1]) |=> r.sleep == SLP_EXIT ##1 awake;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit timing");
endmodule : burst_sram

// ==== sram_defines.svh ====
// Constants of the flow-through burst SRAM
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH
`define SRAM_ADDR_W        18
`define SRAM_DATA_W        32
`define SRAM_LANES         4
`define SRAM_WORD_W        36
`define SRAM_DEPTH         262144
`define SRAM_LANE_W        8
`define SRAM_BURST_W       2
`define SRAM_SLEEP_STEP_CYC 2
`endif

// ==== sram_pkg.sv ====
// Types of the flow-through burst SRAM
`include "sram_defines.svh"
package sram_pkg;
    typedef enum logic [1:0] {
        OP_IDLE  = 2'h0,
        OP_READ  = 2'h1,
        OP_WRITE = 2'h2
    } op_e;
    typedef enum logic [1:0] {
        SLP_AWAKE = 2'h0,
        SLP_ENTER = 2'h1,
        SLP_ASLEEP = 2'h2,
        SLP_EXIT  = 2'h3
    } sleep_e;
    typedef struct packed {
        op_e                      op;
        logic [`SRAM_ADDR_W-1:0]  base;
        logic [`SRAM_BURST_W-1:0] step;
        logic                     read_valid;
        logic                     write_pend;
        logic [`SRAM_ADDR_W-1:0]  wr_addr;
        logic [`SRAM_LANES-1:0]   wr_lanes_n;
        logic [`SRAM_WORD_W-1:0]  rd_word;
        sleep_e                   sleep;
        logic [1:0]               sleep_cnt;
        logic [1:0]               sleep_sync;
        logic [1:0]               order_sync;
    } sram_state_s;
    typedef struct packed {
        logic [2:0] tck_sync;
        logic [1:0] tdi_sync;
        logic [1:0] tms_sync;
        logic       bypass;
        logic       tms;
        logic       tdo;
    } scan_state_s;
endpackage : sram_pkg

// ==== burst_sequencer.sv ====
// Two-bit burst address generator
`timescale 1ns/100ps
module burst_sequencer (
    input  wire logic [1:0] start_i,
    input  wire logic [1:0] step_i,
    input  wire logic       interleaved_i,
    output logic      [1:0] beat_o
);
    // Interleaved xors the step, linear adds it modulo four
    always_comb begin
        if (interleaved_i) begin
            beat_o = start_i ^ step_i;
        end else begin
            beat_o = 2'(start_i + step_i);
        end
    end
endmodule : burst_sequencer

// ==== scan_port.sv ====
// Boundary-scan serial pin sampling
`timescale 1ns/100ps
module scan_port
    import sram_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic tck_i,
    input  wire logic tdi_i,
    input  wire logic tms_i,
    output logic      tdo_o
);
    scan_state_s r, n;
    logic        tck_rise;
    logic        tck_fall;

    // Edges seen on synchronised scan clock
    assign tck_rise = r.tck_sync[1] & ~r.tck_sync[2];
    assign tck_fall = ~r.tck_sync[1] & r.tck_sync[2];

    // Sample inputs on rise, move output on fall
    always_comb begin
        n = r;
        n.tck_sync = {r.tck_sync[1:0], tck_i};
        n.tdi_sync = {r.tdi_sync[0], tdi_i};
        n.tms_sync = {r.tms_sync[0], tms_i};
        if (tck_rise) begin
            n.bypass = r.tdi_sync[1];
            n.tms    = r.tms_sync[1];
        end
        if (tck_fall && !r.tms) begin
            n.tdo = r.bypass;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tdo_o = r.tdo;
endmodule : scan_port

// ==== bus_master_model.sv ====
// Bus master model that drives the burst SRAM pins
`timescale 1ns/100ps
module bus_master_model (
    input  wire logic        clk_sys_i,
    input  wire logic [31:0] data_lines_o,
    input  wire logic [3:0]  parity_lines_o,
    input  wire logic        data_lines_oe_o,
    output logic      [17:0] addr_o,
    output logic             clk_qualifier_n_o,
    output logic             chip_select_1_n_o,
    output logic             chip_select_2_o,
    output logic             chip_select_3_n_o,
    output logic             advance_or_load_o,
    output logic             write_select_n_o,
    output logic      [3:0]  byte_lane_write_n_o,
    output logic             output_drive_n_o,
    output logic             burst_order_o,
    output logic             sleep_request_o,
    output logic      [35:0] bus_word_o
);
    localparam int K_READ = 0, K_WRITE = 1, K_ADV = 2, K_DESEL = 3, K_STALL = 4;
    logic        drv_r;
    logic        pend_r;
    logic        burst_wr_r;
    logic [35:0] drv_d;
    logic [35:0] pend_d;
    logic [35:0] last_d;

    // Idle pins at time zero: deselected, interleaved strap
    initial begin
        {drv_r, pend_r, burst_wr_r, drv_d, pend_d, last_d} = '0;
        {addr_o, clk_qualifier_n_o, chip_select_2_o, chip_select_3_n_o, advance_or_load_o} = '0;
        {chip_select_1_n_o, write_select_n_o, burst_order_o} = 3'h7;
        byte_lane_write_n_o = 4'hF;
        output_drive_n_o    = 1'b0;
        sleep_request_o     = 1'b0;
    end

    // Shared lines: released lines show the inverse of the last level
    always_comb begin
        if (drv_r)
            bus_word_o = drv_d;
        else if (data_lines_oe_o)
            bus_word_o = {parity_lines_o, data_lines_o};
        else
            bus_word_o = ~last_d;
    end

    // One bus cycle; returns what the device showed for the previous one
    task automatic issue(input int kind, input logic [17:0] a, input logic [3:0] ln,
                         input logic [35:0] wd, output logic [35:0] q, output logic oe);
        @(posedge clk_sys_i);
        #1;
        q      = {parity_lines_o, data_lines_o};
        oe     = data_lines_oe_o;
        last_d = bus_word_o;
        if (kind != K_STALL) begin
            drv_r  = pend_r;  // Drives only in the write data phase
            drv_d  = pend_d;
            pend_d = wd;
        end
        clk_qualifier_n_o   = (kind == K_STALL);
        advance_or_load_o   = (kind == K_ADV);
        chip_select_1_n_o   = (kind == K_DESEL);
        chip_select_2_o     = 1'b1;
        chip_select_3_n_o   = 1'b0;
        write_select_n_o    = (kind != K_WRITE);
        addr_o              = a;
        byte_lane_write_n_o = ln;  // Lane pattern given on every beat
        if (kind == K_READ || kind == K_WRITE || kind == K_DESEL)
            burst_wr_r = (kind == K_WRITE);  // Load after deselect is a fresh address
        if (kind != K_STALL)
            pend_r = burst_wr_r;
    endtask : issue

    // Static pins, changed just after an edge with the selects held off
    task automatic set_pins(input logic order, input logic oen, input logic slp);
        @(posedge clk_sys_i);
        #1;
        burst_order_o    = order;
        output_drive_n_o = oen;
        sleep_request_o  = slp;
    endtask : set_pins
endmodule : bus_master_model

// ==== test_flow_through_burst_sram_access.sv ====
// Self-checking testbench of the burst SRAM access control
`timescale 1ns/100ps
module test_flow_through_burst_sram_access;
    localparam int K_READ = 0, K_WRITE = 1, K_ADV = 2, K_DESEL = 3, K_STALL = 4;
    logic        clk_sys_i, rst_n_i, tck_i, tdi_i, tms_i;
    logic [35:0] q;
    logic        oe;
    logic [35:0] exp_mem [16];
    int          miscompares, samples_checked;
    wire  [31:0] data_lines_o;
    wire  [3:0]  parity_lines_o, lanes_n;
    wire         data_lines_oe_o, tdo_o, cq_n, cs1_n, cs2, cs3_n, adv, we_n, oe_n, order, slp;
    wire  [17:0] addr;
    wire  [35:0] bus_word;

    //==========================================
    // Design and master
    burst_sram i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr), .clk_qualifier_n_i(cq_n),
        .chip_select_1_n_i(cs1_n), .chip_select_2_i(cs2), .chip_select_3_n_i(cs3_n),
        .advance_or_load_i(adv), .write_select_n_i(we_n), .byte_lane_write_n_i(lanes_n),
        .output_drive_n_i(oe_n), .burst_order_i(order), .sleep_request_i(slp),
        .data_lines_i(bus_word[31:0]), .parity_lines_i(bus_word[35:32]), .data_lines_o(data_lines_o),
        .parity_lines_o(parity_lines_o), .data_lines_oe_o(data_lines_oe_o), .tck_i(tck_i),
        .tdi_i(tdi_i), .tms_i(tms_i), .tdo_o(tdo_o));
    bus_master_model i_master (.clk_sys_i(clk_sys_i), .data_lines_o(data_lines_o),
        .parity_lines_o(parity_lines_o), .data_lines_oe_o(data_lines_oe_o), .addr_o(addr),
        .clk_qualifier_n_o(cq_n), .chip_select_1_n_o(cs1_n), .chip_select_2_o(cs2),
        .chip_select_3_n_o(cs3_n), .advance_or_load_o(adv), .write_select_n_o(we_n),
        .byte_lane_write_n_o(lanes_n), .output_drive_n_o(oe_n), .burst_order_o(order),
        .sleep_request_o(slp), .bus_word_o(bus_word));

    //==========================================
    // Helpers
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if ((got !== exp) || $isunknown(got)) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic chk_oe(input logic e);
        check({35'h0, oe}, {35'h0, e});
    endtask : chk_oe
    task automatic op(input int kind, input logic [17:0] a, input logic [3:0] ln, input logic [35:0] wd);
        i_master.issue(kind, a, ln, wd, q, oe);
    endtask : op
    task automatic idle();
        op(K_DESEL, 18'h0, 4'hF, 36'h0);
    endtask : idle
    function automatic logic [35:0] pat(input logic [7:0] k);
        return {k[3:0], k, ~k, k + 8'h11, k ^ 8'h5A};
    endfunction : pat
    // Expected word update, lane i is data byte i and parity bit i
    task automatic store(input logic [17:0] a, input logic [3:0] ln, input logic [35:0] w);
        for (int i = 0; i < 4; i++) begin
            if (!ln[i]) begin
                exp_mem[a[3:0]][8*i +: 8] = w[8*i +: 8];
                exp_mem[a[3:0]][32 + i]   = w[32 + i];
            end
        end
    endtask : store

    //==========================================
    // Scenarios
    task automatic burst(input logic wr, input logic [17:0] a, input logic lin, input logic [7:0] k);
        logic [17:0] ad;
        logic [17:0] prev;
        prev = a;
        for (int j = 0; j <= 4; j++) begin
            ad = {a[17:2], lin ? 2'(a[1:0] + 2'(j)) : a[1:0] ^ 2'(j)};
            if (j == 4)
                idle();
            else if (j == 0)
                op(wr ? K_WRITE : K_READ, ad, 4'h0, pat(k));
            else
                op(K_ADV, ~a, 4'h0, pat(k + 8'(j)));  // Address pins ignored on advance
            if (!wr && j > 0) begin
                check(q, exp_mem[prev[3:0]]);
                chk_oe(1'b1);
            end else if (j > 0) begin
                chk_oe(1'b0);
            end
            if (wr && j < 4)
                store(ad, 4'h0, pat(k + 8'(j)));
            prev = ad;
        end
    endtask : burst
    task automatic t_lanes();
        op(K_WRITE, 18'h9, 4'h0, pat(8'h30));
        op(K_WRITE, 18'h9, 4'hA, pat(8'hC3));
        chk_oe(1'b0);
        op(K_READ, 18'h9, 4'hF, 36'h0);
        idle();
        store(18'h9, 4'h0, pat(8'h30));
        store(18'h9, 4'hA, pat(8'hC3));
        check(q, exp_mem[9]);
    endtask : t_lanes
    task automatic t_stall();
        op(K_READ, 18'h4, 4'hF, 36'h0);
        op(K_STALL, 18'h8, 4'hF, 36'h0);
        op(K_ADV, 18'h0, 4'hF, 36'h0);
        check(q, exp_mem[4]);
        chk_oe(1'b1);
        idle();
        check(q, exp_mem[5]);
        op(K_ADV, 18'h0, 4'hF, 36'h0);
        chk_oe(1'b0);
        idle();
        chk_oe(1'b0);
        i_master.set_pins(1'b0, 1'b1, 1'b0);
        op(K_READ, 18'h4, 4'hF, 36'h0);
        idle();
        chk_oe(1'b0);
        i_master.set_pins(1'b0, 1'b0, 1'b0);
    endtask : t_stall
    task automatic t_sleep();
        i_master.set_pins(1'b0, 1'b0, 1'b1);
        repeat (3) idle();
        op(K_READ, 18'h4, 4'hF, 36'h0);
        op(K_READ, 18'h5, 4'hF, 36'h0);
        chk_oe(1'b0);
        idle();
        chk_oe(1'b0);
        i_master.set_pins(1'b0, 1'b0, 1'b0);
        repeat (6) idle();  // Pin sync plus exit, selects held off
        op(K_READ, 18'h4, 4'hF, 36'h0);
        op(K_WRITE, 18'h4, 4'hF, pat(8'h77));
        check(q, exp_mem[4]);
        chk_oe(1'b1);
        op(K_READ, 18'h4, 4'hF, 36'h0);
        chk_oe(1'b0);
        idle();
        check(q, exp_mem[4]);
    endtask : t_sleep
    task automatic t_scan();
        logic prev;
        prev = 1'b0;
        for (int b = 0; b < 4; b++) begin
            @(posedge clk_sys_i);
            #1;
            tdi_i = b[0];
            tms_i = (b == 3);  // Last bit captured with mode high holds the output
            tck_i = 1'b1;
            repeat (6) @(posedge clk_sys_i);
            #1;
            check({35'h0, tdo_o}, {35'h0, prev});
            if (b != 3)
                prev = b[0];
            tck_i = 1'b0;
            repeat (6) @(posedge clk_sys_i);
            #1;
            check({35'h0, tdo_o}, {35'h0, prev});
        end
    endtask : t_scan
    task automatic results();
        $display("Checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    //==========================================
    // Clock, watchdog and main sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        miscompares++;
        results();
    end
    initial begin
        {rst_n_i, tck_i, tdi_i, tms_i} = 4'h0;
        miscompares     = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) idle();
        chk_oe(1'b0);
        burst(1'b1, 18'h5, 1'b0, 8'h10);
        burst(1'b0, 18'h6, 1'b0, 8'h00);
        i_master.set_pins(1'b0, 1'b0, 1'b0);
        repeat (3) idle();
        burst(1'b1, 18'h2, 1'b1, 8'h40);
        burst(1'b0, 18'h7, 1'b1, 8'h00);
        t_lanes();
        t_stall();
        t_sleep();
        t_scan();
        results();
    end
endmodule : test_flow_through_burst_sram_access
